//--- hw/twc_defs.svh
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TWC_FIFO_DEPTH 32
`define TWC_DATA_W 8

// ----------------------------------------------------------------
// Protocol constants and reset values
// ----------------------------------------------------------------
`define TWC_GC_ADDR 8'h00
`define TWC_ACK_BIT 4'h8
`define TWC_TRANSMISSION_COMPLETE_FLAG_RST 1'b1
`define TWC_TX_HOLDING_READY_FLAG_RST 1'b1

`endif

//--- hw/twc_pkg.sv
package twc_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0] twc_byte_t;

  // Bus-level sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAITFREE = 3'h1,
    ST_START = 3'h2,
    ST_LOW = 3'h3,
    ST_HIGH = 3'h4,
    ST_STOPA = 3'h5,
    ST_STOPB = 3'h6,
    ST_SLAVE = 3'h7
  } twc_state_e;

  // Meaning of the byte currently on the wire
  typedef enum logic [2:0] {
    PH_NONE = 3'h0,
    PH_ADDR = 3'h1,
    PH_INTERNAL_ADDRESS_BYTES = 3'h2,
    PH_WDATA = 3'h3,
    PH_RDATA = 3'h4,
    PH_SADDR = 3'h5,
    PH_SREAD = 3'h6,
    PH_SWRITE = 3'h7
  } twc_phase_e;

endpackage

//--- hw/twc_fifo.sv
`timescale 1ns/100ps
module twc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input logic clock,
  input logic rst_n,
  input logic [WIDTH-1:0] inData,
  input logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input logic outReady
);
  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  // Depth must be a power of two: pointers wrap naturally
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW-1:0] next_rp;
  logic [AW:0] next_count;

  // Handshakes and next pointer state
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign next_rp = pop ? AW'(rp + 1'b1) : rp;
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Array write, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp] <= inData;
    end
  end

  // Pointers and flags, flags registered so outputs come from flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      outValid <= 1'b0;
      inReady <= 1'b1;
    end else begin
      if (push) begin
        wp <= AW'(wp + 1'b1);
      end
      rp <= next_rp;
      count <= next_count;
      outValid <= (next_count != '0);
      inReady <= (next_count != FULL_COUNT);
    end
  end

  // Head register; bypass when the new word lands at the head
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outData <= '0;
    end else if (push && (next_rp == wp)) begin
      outData <= inData;
    end else begin
      outData <= mem[next_rp];
    end
  end

endmodule

//--- hw/twc_ctrl.sv
`timescale 1ns/100ps
`include "twc_defs.svh"
module twc_ctrl #(
  parameter int FIFO_DEPTH = `TWC_FIFO_DEPTH
) (
  input logic clock,
  input logic rst_n,
  input logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input logic masterEnableBit,
  input logic masterDisableBit,
  input logic slaveEnableBit,
  input logic slaveDisableBit,
  input logic startCmd,
  input logic stopCmd,
  input logic quickCmd,
  input logic [6:0] targetDeviceAddress,
  input logic masterDirectionBit,
  input logic [1:0] internalAddressSize,
  input logic [23:0] internalAddressBytes,
  input logic [6:0] ownSlaveAddress,
  input logic [2:0] clockDividerExponent,
  input logic [7:0] clockHighDiv,
  input logic [7:0] clockLowDiv,
  input twc_pkg::twc_byte_t txData,
  input logic txWrite,
  output twc_pkg::twc_byte_t rxData,
  output logic rxHoldingReadyFlag,
  input logic rxRead,
  input logic statusRead,
  output logic transmissionCompleteFlag,
  output logic txHoldingReadyFlag,
  output logic nackFlag,
  output logic arbitrationLostFlag,
  output logic slaveAccessFlag,
  output logic slaveReadFlag,
  output logic endSlaveAccessFlag,
  output logic generalCallAccessFlag,
  output logic clockWaitStateFlag
);
  import twc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  twc_state_e state, next_state;
  twc_phase_e phase;
  logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
  logic sclRise, sclFall, startDet, stopDet, busBusy;
  logic masterOn, slaveOn, goReq, stopPend, quickPend;
  logic [7:0] preCnt, phaseCnt, preLimit, target;
  logic tick, cntDone, hiSeen;
  twc_byte_t shReg, txHoldingReg, nextByte;
  logic [3:0] bitCnt;
  logic [1:0] iaLeft;
  logic dataLow, pendSetup, pendAck, engBusyD, stopReq, restartPend, restarted;
  logic lastRead, rsSeen, txFull;
  logic isSlave, riseEv, fallEv, startDone, txDir, needTx, pushPhase;
  logic stall, engBusy, arbEv, loadTx, fifoPush, fifoInReady, dirBit;

  function automatic twc_byte_t iaByte(input logic [23:0] bytes, input logic [1:0] idx);
    case (idx)
      2'h3: iaByte = bytes[23:16];
      2'h2: iaByte = bytes[15:8];
      default: iaByte = bytes[7:0];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD} <= 6'h3F;
    end else begin
      {sclS1, sclS2, sclD} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
    end
  end

  assign sclRise = sclS2 && !sclD;
  assign sclFall = !sclS2 && sclD;
  assign startDet = sclS2 && sclD && sdaD && !sdaS2;
  assign stopDet = sclS2 && sclD && !sdaD && sdaS2;

  // Internal only: no port carries it out
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busBusy <= 1'b0;
    end else if (stopDet) begin
      busBusy <= 1'b0;
    end else if (startDet) begin
      busBusy <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Role and command latches
  // ----------------------------------------------------------------
  // Disable beats enable in the same cycle; roles change only by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      masterOn <= 1'b0;
      slaveOn <= 1'b0;
    end else begin
      if (masterDisableBit) masterOn <= 1'b0;
      else if (masterEnableBit) masterOn <= 1'b1;
      if (slaveDisableBit) slaveOn <= 1'b0;
      else if (slaveEnableBit) slaveOn <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      goReq <= 1'b0;
      stopPend <= 1'b0;
      quickPend <= 1'b0;
    end else if (arbEv || !masterOn) begin
      goReq <= 1'b0;
      stopPend <= 1'b0;
      quickPend <= 1'b0;
    end else begin
      if (state == ST_START) goReq <= 1'b0;
      else if (state == ST_IDLE && (startCmd || quickCmd || txWrite)) goReq <= 1'b1;
      if (state == ST_STOPB) stopPend <= 1'b0;
      else if (stopCmd) stopPend <= 1'b1;
      if (state == ST_STOPB) quickPend <= 1'b0;
      else if (quickCmd && state == ST_IDLE) quickPend <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock waveform divider, master only
  // ----------------------------------------------------------------
  assign preLimit = (8'h01 << clockDividerExponent) - 8'h01;
  assign target = (state == ST_LOW) ? clockLowDiv : clockHighDiv;
  assign cntDone = tick && (phaseCnt >= target);

  always_ff @(posedge clock) begin
    if (!rst_n || isSlave) begin
      preCnt <= 8'h00;
      tick <= 1'b0;
    end else if (preCnt >= preLimit) begin
      preCnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      preCnt <= preCnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // Low phase counts only after the engine settles, so data leads the clock
  always_ff @(posedge clock) begin
    if (!rst_n || state != next_state || (state == ST_LOW && engBusy)) begin
      phaseCnt <= 8'h00;
    end else if ((state == ST_HIGH || state == ST_STOPB) && !hiSeen) begin
      phaseCnt <= 8'h00;
    end else if (tick && phaseCnt != 8'hFF) begin
      phaseCnt <= phaseCnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  assign isSlave = (state == ST_SLAVE);
  assign startDone = (state == ST_START) && cntDone;
  assign riseEv = isSlave ? sclRise : (state == ST_HIGH && !hiSeen && sclS2 && !restartPend);
  assign fallEv = isSlave ? sclFall : (state == ST_HIGH && hiSeen && cntDone && !restartPend);
  assign engBusy = pendSetup || pendAck || engBusyD;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (slaveOn && !masterOn) next_state = ST_SLAVE;
        else if (masterOn && goReq) next_state = ST_WAITFREE;
      end
      ST_WAITFREE: begin
        if (!masterOn) next_state = ST_IDLE;
        else if (!busBusy) next_state = ST_START;
      end
      ST_START: if (cntDone) next_state = ST_LOW;
      ST_LOW: begin
        if (cntDone && !engBusy) next_state = stopReq ? ST_STOPA : ST_HIGH;
      end
      ST_HIGH: if (hiSeen && cntDone) next_state = restartPend ? ST_START : ST_LOW;
      ST_STOPA: if (cntDone) next_state = ST_STOPB;
      ST_STOPB: if (hiSeen && cntDone) next_state = ST_IDLE;
      ST_SLAVE: if (!slaveOn || masterOn) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (arbEv) next_state = ST_IDLE;
  end

  // Pin drivers follow the next state so they change on the same edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      hiSeen <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      state <= next_state;
      hiSeen <= (state == next_state) && (hiSeen || sclS2);
      case (next_state)
        ST_LOW, ST_STOPA: sclOe <= 1'b1;
        ST_SLAVE: sclOe <= stall || engBusyD;
        default: sclOe <= 1'b0;
      endcase
      case (next_state)
        ST_START, ST_STOPA, ST_STOPB: sdaOe <= 1'b1;
        ST_LOW, ST_HIGH, ST_SLAVE: sdaOe <= dataLow;
        default: sdaOe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte engine helpers
  // ----------------------------------------------------------------
  assign txDir = (phase == PH_ADDR) || (phase == PH_INTERNAL_ADDRESS_BYTES) || needTx;
  assign needTx = (phase == PH_WDATA) || (phase == PH_SREAD);
  assign pushPhase = (phase == PH_RDATA) || (phase == PH_SWRITE);
  assign dirBit = quickPend ? masterDirectionBit :
                  (restarted || (internalAddressSize == 2'h0 && masterDirectionBit));
  assign stall = (pendSetup && needTx && !txFull && !(phase == PH_WDATA && stopPend)) ||
                 (pendAck && pushPhase && !fifoInReady);
  assign loadTx = pendSetup && needTx && txFull;
  assign fifoPush = pendAck && pushPhase && fifoInReady;
  assign arbEv = riseEv && !isSlave && txDir && (bitCnt != `TWC_ACK_BIT) && !dataLow && !sdaS2;

  always_comb begin
    case (phase)
      PH_ADDR: nextByte = {targetDeviceAddress, dirBit};
      PH_INTERNAL_ADDRESS_BYTES: nextByte = iaByte(internalAddressBytes, iaLeft);
      PH_WDATA, PH_SREAD: nextByte = txHoldingReg;
      default: nextByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------
  // A fresh write must clear ready even if an ack lands that cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txHoldingReg <= 8'h00;
      txFull <= 1'b0;
      txHoldingReadyFlag <= `TWC_TX_HOLDING_READY_FLAG_RST;
    end else if (txWrite) begin
      txHoldingReg <= txData;
      txFull <= 1'b1;
      txHoldingReadyFlag <= 1'b0;
    end else begin
      if (loadTx) txFull <= 1'b0;
      if (riseEv && bitCnt == `TWC_ACK_BIT && needTx && !txFull) begin
        txHoldingReadyFlag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte engine and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= PH_NONE;
      bitCnt <= 4'h0;
      shReg <= 8'h00;
      iaLeft <= 2'h0;
      {dataLow, pendSetup, pendAck, engBusyD, stopReq, restartPend} <= 6'h00;
      {restarted, lastRead, rsSeen} <= 3'h0;
      transmissionCompleteFlag <= `TWC_TRANSMISSION_COMPLETE_FLAG_RST;
      {nackFlag, arbitrationLostFlag, slaveAccessFlag, slaveReadFlag} <= 4'h0;
      {endSlaveAccessFlag, generalCallAccessFlag, clockWaitStateFlag} <= 3'h0;
    end else begin
      engBusyD <= pendSetup || pendAck;
      clockWaitStateFlag <= isSlave && stall;
      if (statusRead) begin
        {nackFlag, arbitrationLostFlag, endSlaveAccessFlag, generalCallAccessFlag} <= 4'h0;
      end
      if (state == ST_START) dataLow <= 1'b1;
      if (state == ST_STOPB && next_state == ST_IDLE) begin
        transmissionCompleteFlag <= 1'b1;
        stopReq <= 1'b0;
        phase <= PH_NONE;
      end
      if (isSlave && startDet) begin
        if (slaveAccessFlag) endSlaveAccessFlag <= 1'b1;
        rsSeen <= slaveAccessFlag;
        slaveAccessFlag <= 1'b0;
        phase <= PH_SADDR;
        bitCnt <= 4'h0;
        {dataLow, pendSetup, pendAck} <= 3'h0;
      end else if (isSlave && stopDet) begin
        if (slaveAccessFlag) begin
          endSlaveAccessFlag <= 1'b1;
          transmissionCompleteFlag <= 1'b1;
        end
        {slaveAccessFlag, rsSeen} <= 2'h0;
        phase <= PH_NONE;
        {dataLow, pendSetup, pendAck} <= 3'h0;
      end else if (arbEv) begin
        arbitrationLostFlag <= 1'b1;
        transmissionCompleteFlag <= 1'b1;
        phase <= PH_NONE;
        {dataLow, pendSetup, pendAck, stopReq, restartPend} <= 5'h00;
      end else if (startDone) begin
        phase <= PH_ADDR;
        bitCnt <= 4'h0;
        pendSetup <= 1'b1;
        restarted <= restartPend;
        restartPend <= 1'b0;
        transmissionCompleteFlag <= 1'b0;
      end else if (phase != PH_NONE) begin
        // Sample on the rising edge; the ninth bit is the acknowledge
        if (riseEv && bitCnt != `TWC_ACK_BIT) begin
          shReg <= {shReg[6:0], sdaS2};
          bitCnt <= bitCnt + 4'h1;
        end else if (riseEv) begin
          bitCnt <= 4'h0;
          case (phase)
            PH_ADDR: begin
              if (sdaS2) {nackFlag, stopReq} <= 2'h3;
              else if (quickPend) stopReq <= 1'b1;
              else if (internalAddressSize != 2'h0 && !restarted) begin
                phase <= PH_INTERNAL_ADDRESS_BYTES;
                iaLeft <= internalAddressSize;
              end else phase <= masterDirectionBit ? PH_RDATA : PH_WDATA;
            end
            PH_INTERNAL_ADDRESS_BYTES: begin
              iaLeft <= iaLeft - 2'h1;
              if (sdaS2) {nackFlag, stopReq} <= 2'h3;
              else if (iaLeft == 2'h1 && masterDirectionBit) restartPend <= 1'b1;
              else if (iaLeft == 2'h1) phase <= PH_WDATA;
            end
            PH_WDATA: if (sdaS2) {nackFlag, stopReq} <= 2'h3;
            PH_RDATA: if (lastRead) stopReq <= 1'b1;
            PH_SREAD: begin
              if (sdaS2) begin
                nackFlag <= 1'b1;
                phase <= PH_NONE;
              end
            end
            default: bitCnt <= 4'h0;
          endcase
        end
        // Drive on the falling edge: byte setup, data bits, acknowledge
        if (fallEv && bitCnt == 4'h0) begin
          if (stopReq || restartPend) dataLow <= 1'b0;
          else pendSetup <= 1'b1;
        end else if (fallEv && bitCnt == `TWC_ACK_BIT) begin
          if (txDir) dataLow <= 1'b0;
          else pendAck <= 1'b1;
        end else if (fallEv) begin
          dataLow <= txDir && !shReg[7];
        end
        if (pendSetup && phase == PH_WDATA && !txFull && stopPend) begin
          pendSetup <= 1'b0;
          stopReq <= 1'b1;
          dataLow <= 1'b0;
        end else if (pendSetup && !stall) begin
          pendSetup <= 1'b0;
          shReg <= nextByte;
          dataLow <= txDir && !nextByte[7];
        end
        if (pendAck) begin
          case (phase)
            PH_SADDR: begin
              pendAck <= 1'b0;
              if (shReg[7:1] == ownSlaveAddress && !arbitrationLostFlag) begin
                {slaveAccessFlag, slaveReadFlag} <= {1'b1, shReg[0]};
                transmissionCompleteFlag <= 1'b0;
                phase <= shReg[0] ? PH_SREAD : PH_SWRITE;
                dataLow <= 1'b1;
              end else if (shReg == `TWC_GC_ADDR) begin
                generalCallAccessFlag <= 1'b1;
                phase <= PH_SWRITE;
                dataLow <= 1'b1;
              end else begin
                phase <= PH_NONE;
                dataLow <= 1'b0;
                if (rsSeen) transmissionCompleteFlag <= 1'b1;
              end
            end
            PH_RDATA, PH_SWRITE: begin
              if (fifoInReady) begin
                pendAck <= 1'b0;
                dataLow <= (phase == PH_SWRITE) || !stopPend;
                lastRead <= (phase == PH_RDATA) && stopPend;
              end
            end
            default: pendAck <= 1'b0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path buffer; a full buffer stretches the clock
  // ----------------------------------------------------------------
  twc_fifo #(
    .WIDTH(`TWC_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .clock(clock),
    .rst_n(rst_n),
    .inData(shReg),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(rxData),
    .outValid(rxHoldingReadyFlag),
    .outReady(rxRead)
  );

endmodule

//--- bench/twc_ctrl_properties.sv
`timescale 1ns/100ps
// ----
// Port checks
// ----
module twc_ctrl_properties (
  input logic clock,
  input logic rst_n,
  input logic sclIn,
  input logic sclOut,
  input logic sclOe,
  input logic sdaOut,
  input logic sdaOe,
  input logic txWrite,
  input logic txHoldingReadyFlag,
  input logic transmissionCompleteFlag,
  input logic arbitrationLostFlag,
  input logic slaveAccessFlag,
  input logic endSlaveAccessFlag,
  input logic generalCallAccessFlag,
  input logic clockWaitStateFlag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Sync delay allowed for; SDA only moves once SCL is seen low
  a_slave_sda_quiet: assert property (slaveAccessFlag && sclIn && $past(sclIn, 3) |-> $stable(sdaOe))
    else $error("slave moved SDA under high SCL");
  a_open_drain: assert property (sclOut == 1'h0 && sdaOut == 1'h0)
    else $error("line driven high");
  a_match_busy: assert property ($rose(slaveAccessFlag) |-> ##[0:1] !transmissionCompleteFlag)
    else $error("complete flag stays up on access");
  a_end_drops_acc: assert property ($rose(endSlaveAccessFlag) |-> !slaveAccessFlag)
    else $error("access flag held past end");
  a_arb_release: assert property ($rose(arbitrationLostFlag) |-> ##[0:2] (!sdaOe && !sclOe && transmissionCompleteFlag))
    else $error("lines kept after lost arbitration");
  a_arb_no_ack: assert property (arbitrationLostFlag |-> !$rose(slaveAccessFlag))
    else $error("own address taken after lost arbitration");
  a_stretch_flag: assert property ($rose(clockWaitStateFlag) |-> ##[0:1] sclOe)
    else $error("wait flag without stretch");
  a_write_clears_rdy: assert property (txWrite |=> !txHoldingReadyFlag)
    else $error("tx ready kept after write");
  a_gc_no_access: assert property ($rose(generalCallAccessFlag) |-> !slaveAccessFlag)
    else $error("general call raised access flag");
  cover property ($rose(slaveAccessFlag));
  cover property ($rose(arbitrationLostFlag));
  cover property ($rose(clockWaitStateFlag));
endmodule

//--- bench/twc_bus_slave.sv
`timescale 1ns/100ps
// ----
// Far-side target
// ----
module twc_bus_slave #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  output logic sdaOe
);
  logic [7:0] got[$];
  logic [7:0] sh = 8'h00;
  int bits = 0;
  logic sel = 1'h0;
  logic first = 1'h0;
  logic ok = 1'h0;
  initial sdaOe = 1'h0;
  // START arms, STOP releases the line
  always @(sda) if (scl) begin
    sel = !sda;
    first = 1'h1;
    bits = 0;
    sdaOe <= 1'h0;
  end
  // Bits taken MSB first on each rise
  always @(posedge scl) if (sel && bits < 8) begin
    sh = {sh[6:0], sda};
    bits++;
  end
  // Ack held from the 8th fall to the 9th; a wrong address stays silent
  always @(negedge scl) if (sel) begin
    if (bits == 8) begin
      got.push_back(sh);
      ok = first ? (sh[7:1] == ADDR) : ok;
      first = 1'h0;
      sdaOe <= ok;
      bits = 9;
    end else if (bits == 9) begin
      sdaOe <= 1'h0;
      bits = 0;
    end
  end
endmodule

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import twc_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic tbSclOe = 1'h0;
  logic tbSdaOe = 1'h0;
  logic pSdaOe, sclOut, sclOe, sdaOut, sdaOe, rxHoldingReadyFlag, transmissionCompleteFlag, ack;
  logic txHoldingReadyFlag, nackFlag, arbitrationLostFlag, slaveAccessFlag, slaveReadFlag;
  logic endSlaveAccessFlag, generalCallAccessFlag, clockWaitStateFlag;
  logic masterEnableBit = 1'h0, masterDisableBit = 1'h0, slaveEnableBit = 1'h0;
  logic slaveDisableBit = 1'h0, startCmd = 1'h0, stopCmd = 1'h0, quickCmd = 1'h0;
  logic masterDirectionBit = 1'h0, txWrite = 1'h0, rxRead = 1'h0, statusRead = 1'h0;
  logic [6:0] targetDeviceAddress = 7'h2A;
  logic [6:0] ownSlaveAddress = 7'h35;
  logic [2:0] clockDividerExponent = 3'h0;
  logic [7:0] clockHighDiv = 8'h06;
  logic [7:0] clockLowDiv = 8'h06;
  logic [1:0] internalAddressSize = 2'h2;
  logic [23:0] internalAddressBytes = 24'h5AC3E1;
  twc_byte_t txData = 8'h96;
  twc_byte_t rxData;
  int error_cnt = 0;
  int comparisons = 0;
  // Wired-AND with pull-ups
  wire sclIn = !(sclOe || tbSclOe);
  wire sdaIn = !(sdaOe || pSdaOe || tbSdaOe);
  twc_ctrl #(.FIFO_DEPTH(32)) dut_u (.clock, .rst_n, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut,
    .sdaOe, .masterEnableBit, .masterDisableBit, .slaveEnableBit, .slaveDisableBit, .startCmd,
    .stopCmd, .quickCmd, .targetDeviceAddress, .masterDirectionBit, .internalAddressSize,
    .internalAddressBytes, .ownSlaveAddress, .clockDividerExponent, .clockHighDiv, .clockLowDiv,
    .txData, .txWrite, .rxData, .rxHoldingReadyFlag, .rxRead, .statusRead,
    .transmissionCompleteFlag, .txHoldingReadyFlag, .nackFlag, .arbitrationLostFlag,
    .slaveAccessFlag, .slaveReadFlag, .endSlaveAccessFlag, .generalCallAccessFlag,
    .clockWaitStateFlag);
  twc_bus_slave #(.ADDR(7'h2A)) partner_u (.scl(sclIn), .sda(sdaIn), .sdaOe(pSdaOe));
  // Clock and a watchdog that ends a hang
  initial forever #2.5 clock = ~clock;
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  task finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  // Bounded polls; a stuck flag shows up in the next compare
  task automatic waitfor(ref logic f, input logic v);
    for (int n = 0; n < 20000 && f !== v; n++) tick(1);
  endtask
  task waitbytes(input int k);
    for (int n = 0; n < 20000 && partner_u.got.size() < k; n++) tick(1);
  endtask
  // Bit-banged master on the testbench's own open-drain pair; honours stretching
  task bbit(input logic b, output logic r);
    tbSdaOe = !b;
    tick(10);
    tbSclOe = 1'h0;
    for (int n = 0; n < 400 && !sclIn; n++) tick(1);
    tick(10);
    r = sdaIn;
    tbSclOe = 1'h1;
  endtask
  task bbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bbit(d[i], r);
    bbit(1'h1, r);
    ack = !r;
  endtask
  task bstart;
    tbSdaOe = 1'h1;
    tick(10);
    tbSclOe = 1'h1;
  endtask
  task bstop;
    tbSdaOe = 1'h1;
    tick(10);
    tbSclOe = 1'h0;
    tick(10);
    tbSdaOe = 1'h0;
    tick(10);
  endtask
  task t_reset;
    chk({transmissionCompleteFlag, txHoldingReadyFlag, nackFlag, arbitrationLostFlag,
      slaveAccessFlag, endSlaveAccessFlag, generalCallAccessFlag, clockWaitStateFlag,
      rxHoldingReadyFlag, sclOe, sdaOe}, 11'h600);
  endtask
  // Master write with two internal address bytes
  task t_mwrite;
    logic [7:0] exp [4];
    exp = '{{targetDeviceAddress, 1'h0}, internalAddressBytes[15:8], internalAddressBytes[7:0],
      txData};
    pulse(slaveDisableBit);
    pulse(masterEnableBit);
    pulse(txWrite);
    chk(txHoldingReadyFlag, 1'h0);
    pulse(stopCmd);
    waitbytes(4);
    waitfor(transmissionCompleteFlag, 1'h1);
    for (int i = 0; i < 4; i++) chk(partner_u.got[i], exp[i]);
    chk(nackFlag, 1'h0);
  endtask
  task t_quick;
    partner_u.got.delete();
    masterDirectionBit = 1'h1;
    pulse(quickCmd);
    waitbytes(1);
    waitfor(transmissionCompleteFlag, 1'h1);
    chk(partner_u.got[0], {targetDeviceAddress, 1'h1});
  endtask
  task t_tenbit;
    partner_u.got.delete();
    internalAddressSize = 2'h1;
    targetDeviceAddress = {5'h1E, 2'h1};
    pulse(txWrite);
    waitbytes(1);
    waitfor(transmissionCompleteFlag, 1'h1);
    chk(partner_u.got[0], {5'h1E, 2'h1, 1'h0});
    chk(nackFlag, 1'h1);
  endtask
  // Testbench holds SDA low against an all-ones address
  task t_arb;
    targetDeviceAddress = 7'h7F;
    pulse(startCmd);
    waitfor(sdaOe, 1'h1);
    tbSdaOe = 1'h1;
    waitfor(arbitrationLostFlag, 1'h1);
    chk(arbitrationLostFlag, 1'h1);
    tick(4);
    chk({sclOe, slaveAccessFlag}, 2'h0);
    tbSdaOe = 1'h0;
    waitfor(transmissionCompleteFlag, 1'h1);
    pulse(masterDisableBit);
    pulse(slaveEnableBit);
    bstart();
    bbyte({ownSlaveAddress, 1'h0});
    bstop();
    chk({ack, slaveAccessFlag}, 2'h0);
    pulse(statusRead);
    chk(arbitrationLostFlag, 1'h0);
  endtask
  // Slave write filling the receive FIFO until it stretches
  task t_swrite;
    bstart();
    bbyte({ownSlaveAddress, 1'h0});
    chk({ack, slaveAccessFlag, slaveReadFlag, transmissionCompleteFlag}, 4'hC);
    for (int i = 0; i < 32; i++) bbyte(8'(i));
    chk(ack, 1'h1);
    fork
      bbyte(8'h20);
      begin
        waitfor(clockWaitStateFlag, 1'h1);
        chk({clockWaitStateFlag, rxData}, 9'h100);
        pulse(rxRead);
      end
    join
    bstop();
    chk({slaveAccessFlag, endSlaveAccessFlag, transmissionCompleteFlag}, 3'h3);
    for (int i = 1; i < 33; i++) begin
      chk(rxData, i);
      pulse(rxRead);
      tick(1);
    end
    chk(rxHoldingReadyFlag, 1'h0);
  endtask
  task t_gcall;
    pulse(statusRead);
    bstart();
    bbyte(8'h00);
    bbyte(8'h04);
    bstop();
    chk({ack, generalCallAccessFlag, rxData}, 10'h304);
  endtask
  // One byte read from us, nacked
  task t_sread;
    logic [7:0] d;
    pulse(txWrite);
    bstart();
    bbyte({ownSlaveAddress, 1'h1});
    chk({ack, slaveAccessFlag, slaveReadFlag}, 3'h7);
    for (int i = 7; i >= 0; i--) bbit(1'h1, d[i]);
    bbit(1'h1, ack);
    bstop();
    chk(d, txData);
    chk({nackFlag, txHoldingReadyFlag, transmissionCompleteFlag}, 3'h7);
  endtask
  initial begin
    tick(5);
    rst_n = 1'h1;
    tick(1);
    t_reset();
    t_mwrite();
    t_quick();
    t_tenbit();
    t_arb();
    t_swrite();
    t_gcall();
    t_sread();
    finish_test();
  end
endmodule
bind twc_ctrl twc_ctrl_properties chk_u (.clock, .rst_n, .sclIn, .sclOut, .sclOe, .sdaOut,
  .sdaOe, .txWrite, .txHoldingReadyFlag, .transmissionCompleteFlag, .arbitrationLostFlag,
  .slaveAccessFlag, .endSlaveAccessFlag, .generalCallAccessFlag, .clockWaitStateFlag);
